// File: hw/ccfc_defines.vh
`ifndef CCFC_DEFINES_VH
`define CCFC_DEFINES_VH
// ***************************************************************
// Register map (byte addresses, Avalon word aligned)
// ***************************************************************
`define CCFC_ADDR_W 4
`define CCFC_OFF_CTRL 4'h0
`define CCFC_OFF_IRQ_STAT 4'h4
`define CCFC_OFF_IRQ_MASK 4'h8
// ***************************************************************
// Control register fields
// ***************************************************************
`define CCFC_SIDL_BIT 13
`define CCFC_TSEL_HI 12
`define CCFC_TSEL_LO 10
`define CCFC_FLTB_EN_BIT 8
`define CCFC_FLTA_EN_BIT 7
`define CCFC_FLTB_ST_BIT 5
`define CCFC_FLTA_ST_BIT 4
`define CCFC_TRIGMODE_BIT 3
`define CCFC_MODE_HI 2
`define CCFC_MODE_LO 0
`define CCFC_CTRL_WMASK 16'h3D8F
`define CCFC_CTRL_RESET 16'h0000
// ***************************************************************
// Clock select codes
// ***************************************************************
`define CCFC_TSEL_T2 3'h0
`define CCFC_TSEL_T3 3'h1
`define CCFC_TSEL_T4 3'h2
`define CCFC_TSEL_T5 3'h3
`define CCFC_TSEL_T1 3'h4
`define CCFC_TSEL_TRIG 3'h5
`define CCFC_TSEL_PERIPH 3'h7
// ***************************************************************
// Interrupt status layout
// ***************************************************************
`define CCFC_IRQ_FLTA 0
`define CCFC_IRQ_FLTB 1
`define CCFC_IRQ_W 2
`endif

// File: hw/ccfc_top.v
// Operation
// [RULE1] Clock select codes pick timers two to five
// [RULE2] Fault enable bits gate their fault pins
// [RULE3] Fault B event sets fault B status
// [RULE4] Fault A event sets fault A status
// [RULE5] Trigger outputs four-seven clock instances one-four
// [RULE6] Fault forces output inactive until cleared, released
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/100ps
`include "ccfc_defines.vh"
module ccfc_top #(
	parameter INSTANCE = 1
) (
	input wire clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	input wire timer_one_clock,
	input wire timer_two_clock,
	input wire timer_three_clock,
	input wire timer_four_clock,
	input wire timer_five_clock,
	input wire trigger_gen_output_four,
	input wire trigger_gen_output_five,
	input wire trigger_gen_output_six,
	input wire trigger_gen_output_seven,
	input wire fault_a_pin,
	input wire fault_b_pin,
	input wire compare_raw,
	output reg compare_channel,
	output reg time_base_tick,
	output wire [2:0] compare_mode,
	output wire trigger_mode,
	output wire stop_in_idle,
	output wire irq
);
	// ***************************************************************
	// Pin synchronisers
	// ***************************************************************
	wire [10:0] pin_async;
	wire [10:0] sync2_w;
	wire [10:0] rise;
	assign pin_async = {fault_b_pin, fault_a_pin, trigger_gen_output_seven,
		trigger_gen_output_six, trigger_gen_output_five, trigger_gen_output_four,
		timer_five_clock, timer_four_clock, timer_three_clock, timer_two_clock,
		timer_one_clock};
	// Two stages cost two cycles of fault latency; a faster path would
	// need an asynchronous clear of the output, which was not worth it
	genvar gi;
	generate
		for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
			reg meta_q;
			reg stable_q;
			reg prev_q;
			always @(posedge clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					stable_q <= 1'b0;
					prev_q <= 1'b0;
				end else begin
					meta_q <= pin_async[gi];
					stable_q <= meta_q;
					prev_q <= stable_q;
				end
			end
			assign sync2_w[gi] = stable_q;
			// Both stages reset low like the idle pins, so reset makes no false edge
			assign rise[gi] = stable_q & ~prev_q;
		end
	endgenerate
	wire flt_a_lvl = sync2_w[9];
	wire flt_b_lvl = sync2_w[10];
	// ***************************************************************
	// Registers
	// ***************************************************************
	reg [15:0] ctrl_q;
	reg [`CCFC_IRQ_W-1:0] stat_q;
	reg [`CCFC_IRQ_W-1:0] mask_q;
	reg ack_q;
	// ***************************************************************
	// Bus handshake
	// ***************************************************************
	// A write lands only on the completing edge, never in the wait cycle
	wire req = avs_read | avs_write;
	// One wait cycle per access, so every access completes on the second edge
	assign avs_waitrequest = req & ~ack_q;
	wire acc = req & ack_q;
	wire wr = acc & avs_write;
	wire wr_ctrl = wr & (avs_address == `CCFC_OFF_CTRL);
	wire wr_stat = wr & (avs_address == `CCFC_OFF_IRQ_STAT) & avs_byteenable[0];
	wire wr_mask = wr & (avs_address == `CCFC_OFF_IRQ_MASK) & avs_byteenable[0];
	wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wmask = be_mask & `CCFC_CTRL_WMASK;
	// ***************************************************************
	// Control register
	// ***************************************************************
	wire fa_en = ctrl_q[`CCFC_FLTA_EN_BIT];
	wire fb_en = ctrl_q[`CCFC_FLTB_EN_BIT];
	wire fa_set = fa_en & flt_a_lvl; // [RULE2]
	wire fb_set = fb_en & flt_b_lvl; // [RULE2]
	reg [15:0] ctrl_d;
	always @* begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = (ctrl_q & ~wmask) | (avs_writedata[15:0] & wmask);
			// Status bits take software clears only
			if (avs_byteenable[0] & ~avs_writedata[`CCFC_FLTA_ST_BIT])
				ctrl_d[`CCFC_FLTA_ST_BIT] = 1'b0;
			if (avs_byteenable[0] & ~avs_writedata[`CCFC_FLTB_ST_BIT])
				ctrl_d[`CCFC_FLTB_ST_BIT] = 1'b0;
		end
		// Hardware set wins over a simultaneous software clear
		if (fa_set)
			ctrl_d[`CCFC_FLTA_ST_BIT] = 1'b1; // [RULE4]
		if (fb_set)
			ctrl_d[`CCFC_FLTB_ST_BIT] = 1'b1; // [RULE3]
	end
	always @(posedge clk) begin
		if (rst) begin
			ctrl_q <= `CCFC_CTRL_RESET;
			ack_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ack_q <= req & ~ack_q;
		end
	end
	// ***************************************************************
	// Interrupt status and mask
	// ***************************************************************
	// Only the first set of a fault status is an event, so a fault that
	// stays live does not raise the interrupt again once it is cleared
	wire [`CCFC_IRQ_W-1:0] ev;
	assign ev[`CCFC_IRQ_FLTA] = fa_set & ~ctrl_q[`CCFC_FLTA_ST_BIT];
	assign ev[`CCFC_IRQ_FLTB] = fb_set & ~ctrl_q[`CCFC_FLTB_ST_BIT];
	always @(posedge clk) begin
		if (rst) begin
			stat_q <= {`CCFC_IRQ_W{1'b0}};
			mask_q <= {`CCFC_IRQ_W{1'b0}};
		end else begin
			if (wr_stat) begin
				stat_q <= (stat_q & ~avs_writedata[`CCFC_IRQ_W-1:0]) | ev;
			end else begin
				stat_q <= stat_q | ev;
			end
			if (wr_mask) begin
				mask_q <= avs_writedata[`CCFC_IRQ_W-1:0];
			end
		end
	end
	assign irq = |(stat_q & mask_q);
	// ***************************************************************
	// Read data
	// ***************************************************************
	reg [31:0] rdata_d;
	always @* begin
		case (avs_address)
			`CCFC_OFF_CTRL: rdata_d = {16'h0000, ctrl_q};
			`CCFC_OFF_IRQ_STAT: rdata_d = {{(32-`CCFC_IRQ_W){1'b0}}, stat_q};
			`CCFC_OFF_IRQ_MASK: rdata_d = {{(32-`CCFC_IRQ_W){1'b0}}, mask_q};
			default: rdata_d = 32'h00000000;
		endcase
	end
	// Loaded in the wait cycle, so the word already stands when the access completes
	always @(posedge clk) begin
		if (rst) begin
			avs_readdata <= 32'h00000000;
		end else if (req & ~ack_q & avs_read) begin
			avs_readdata <= rdata_d;
		end
	end
	// ***************************************************************
	// Mode outputs
	// ***************************************************************
	assign compare_mode = ctrl_q[`CCFC_MODE_HI:`CCFC_MODE_LO];
	assign trigger_mode = ctrl_q[`CCFC_TRIGMODE_BIT];
	assign stop_in_idle = ctrl_q[`CCFC_SIDL_BIT];
	// ***************************************************************
	// Time base selection
	// ***************************************************************
	// Each instance listens to its own trigger output; the other three go unused
	reg trig_rise;
	always @* begin
		case (INSTANCE)
			1: trig_rise = rise[5]; // [RULE5]
			2: trig_rise = rise[6]; // [RULE5]
			3: trig_rise = rise[7]; // [RULE5]
			4: trig_rise = rise[8]; // [RULE5]
			default: trig_rise = 1'b0;
		endcase
	end
	reg tick_d;
	always @* begin
		case (ctrl_q[`CCFC_TSEL_HI:`CCFC_TSEL_LO])
			`CCFC_TSEL_T2: tick_d = rise[1]; // [RULE1]
			`CCFC_TSEL_T3: tick_d = rise[2]; // [RULE1]
			`CCFC_TSEL_T4: tick_d = rise[3]; // [RULE1]
			`CCFC_TSEL_T5: tick_d = rise[4]; // [RULE1]
			`CCFC_TSEL_T1: tick_d = rise[0];
			`CCFC_TSEL_TRIG: tick_d = trig_rise; // [RULE5]
			// Peripheral clock: the time base advances on every cycle
			`CCFC_TSEL_PERIPH: tick_d = 1'b1;
			// Code 110 is reserved and gives no ticks
			default: tick_d = 1'b0;
		endcase
	end
	// ***************************************************************
	// Fault blanking of the compare output
	// ***************************************************************
	// Held while a status bit is set or an enabled pin is still active,
	// so clearing the bit during a live fault does not release the output
	wire fault_seen = ctrl_q[`CCFC_FLTA_ST_BIT] | ctrl_q[`CCFC_FLTB_ST_BIT];
	wire fault_live = fa_set | fb_set;
	wire hold = fault_seen | fault_live;
	always @(posedge clk) begin
		if (rst) begin
			compare_channel <= 1'b0;
			time_base_tick <= 1'b0;
		end else begin
			time_base_tick <= tick_d;
			compare_channel <= hold ? 1'b0 : compare_raw; // [RULE6]
		end
	end
endmodule

// File: verification/ccfc_properties.sv
`timescale 1ns/100ps
module ccfc_properties (
	input wire clk,
	input wire rst,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire fault_a_pin,
	input wire fault_b_pin,
	input wire compare_channel,
	input wire time_base_tick,
	input wire irq
);
	reg [1:0] en_q;
	wire take = (avs_read | avs_write) & !avs_waitrequest;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow of the fault enables, so pin checks know when a fault may act
	always @(posedge clk) begin
		if (rst)
			en_q <= 2'h0;
		else if (take && avs_write && avs_address == 4'h0)
			en_q <= avs_writedata[8:7];
	end
	a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
		else $error("no wait cycle");
	a_wait_once: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait too long");
	a_unmapped_zero: assert property (take && avs_read && avs_address == 4'hC |=> avs_readdata == 0)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (take && avs_read && avs_address == 4'h0
		|=> (avs_readdata & 32'hFFFFC240) == 0) else $error("reserved bit set");
	a_fault_a_blank: assert property ((fault_a_pin && en_q[0])[*8] |-> !compare_channel)
		else $error("fault a not blanking");
	a_fault_b_blank: assert property ((fault_b_pin && en_q[1])[*8] |-> !compare_channel)
		else $error("fault b not blanking");
	cover property (irq);
	cover property (time_base_tick);
	cover property (take && avs_write);
endmodule
bind ccfc_top ccfc_properties i_ccfc_properties (.clk(clk), .rst(rst), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fault_a_pin(fault_a_pin),
	.fault_b_pin(fault_b_pin), .compare_channel(compare_channel),
	.time_base_tick(time_base_tick), .irq(irq));

// File: verification/ccfc_far_model.sv
`timescale 1ns/100ps
module ccfc_far_model (
	input wire clk,
	input wire rst,
	input wire fa_req,
	input wire fb_req,
	output wire fault_a,
	output wire fault_b,
	output reg [7:0] src_q
);
	// Counter bits as sources: any 256-cycle window holds an exact edge count
	always @(posedge clk) begin
		if (rst)
			src_q <= 8'h00;
		else
			src_q <= src_q + 8'h01;
	end
	assign fault_a = fa_req;
	assign fault_b = fb_req;
endmodule

// File: verification/ccfc_top_test.sv
`timescale 1ns/100ps
module ccfc_top_test;
	reg clk = 0, rst = 1, avs_read = 0, avs_write = 0, fa = 0, fb = 0;
	reg [3:0] avs_address = 4'h0;
	reg [31:0] avs_writedata = 32'h0, rd_q;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, cc, tick, irq, fpa, fpb;
	wire [2:0] cm;
	wire trg, sidl;
	wire [7:0] s;
	integer fails = 0, checks_done = 0, cyc = 0, i, n;
	integer exp_n [0:7] = '{32, 16, 8, 4, 64, 2, 0, 256};
	ccfc_far_model i_ccfc_far_model (.clk(clk), .rst(rst), .fa_req(fa), .fb_req(fb),
		.fault_a(fpa), .fault_b(fpb), .src_q(s));
	ccfc_top i_ccfc_top (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .timer_one_clock(s[1]),
		.timer_two_clock(s[2]), .timer_three_clock(s[3]), .timer_four_clock(s[4]),
		.timer_five_clock(s[5]), .trigger_gen_output_four(s[6]), .trigger_gen_output_five(s[7]),
		.trigger_gen_output_six(s[0]), .trigger_gen_output_seven(s[0]), .fault_a_pin(fpa),
		.fault_b_pin(fpb), .compare_raw(1'b1), .compare_channel(cc), .time_base_tick(tick),
		.compare_mode(cm), .trigger_mode(trg), .stop_in_idle(sidl), .irq(irq));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			report_and_stop;
		end
	end
	task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("mismatch %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task acc(input [3:0] a, input w, input [31:0] d);
		begin
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			@(posedge clk);
			while (avs_waitrequest !== 1'b0) @(posedge clk);
			rd_q = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd(input [3:0] a, input [31:0] e);
		begin
			acc(a, 1'b0, 32'h0);
			chk("reg", e, rd_q);
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d mismatches %0d", checks_done, fails);
			if (fails == 0 && checks_done > 0)
				$display("Finished cleanly");
			else
				$display("Finished with errors");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		acc(4'h0, 1'b1, 32'hFFFF);
		rd(4'h0, 32'h3D8F);
		chk("mode", 32'h1F, {sidl, trg, cm});
		acc(4'hC, 1'b1, 32'hFFFF);
		rd(4'hC, 32'h0);
		$display("test registers done");
		for (i = 0; i < 8; i = i + 1) begin
			acc(4'h0, 1'b1, i << 10);
			repeat (16) @(posedge clk);
			n = 0;
			repeat (256) begin
				@(posedge clk);
				n = n + tick;
			end
			chk("ticks", exp_n[i], n);
		end
		$display("test clock select done");
		acc(4'h8, 1'b1, 32'h3);
		acc(4'h0, 1'b1, 32'h80);
		fb <= 1'b1;
		repeat (10) @(posedge clk);
		rd(4'h0, 32'h80);
		chk("out", 1, cc);
		fa <= 1'b1;
		repeat (10) @(posedge clk);
		rd(4'h0, 32'h90);
		chk("irq", 1, irq);
		chk("out", 0, cc);
		fa <= 1'b0;
		acc(4'h4, 1'b1, 32'h1);
		repeat (10) @(posedge clk);
		chk("out", 0, cc);
		chk("irq", 0, irq);
		acc(4'h0, 1'b1, 32'h80);
		repeat (4) @(posedge clk);
		chk("out", 1, cc);
		acc(4'h0, 1'b1, 32'h100);
		repeat (10) @(posedge clk);
		rd(4'h0, 32'h120);
		rd(4'h4, 32'h2);
		chk("irq", 1, irq);
		chk("out", 0, cc);
		acc(4'h0, 1'b1, 32'h100);
		rd(4'h0, 32'h120);
		acc(4'h8, 1'b1, 32'h0);
		chk("irq", 0, irq);
		fb <= 1'b0;
		repeat (4) @(posedge clk);
		acc(4'h0, 1'b1, 32'h100);
		repeat (4) @(posedge clk);
		chk("out", 1, cc);
		$display("test faults done");
		report_and_stop;
	end
endmodule
